/* rtl/mcu_port_pin_control.sv */
// Purpose: Port 1 and port 4 pin control, edge test flag, external irq edges.
// Assumes: Pins and software strobes synchronous to ref_clk.
// Notes:   Software access is by plain write strobes and level ports.
`timescale 1ns/10ps
module mcu_port_pin_control (
  input  wire logic                            ref_clk,
  input  wire logic                            rst,
  input  wire logic [port_ctrl_pkg::PORT_W-1:0] wr_data,
  input  wire logic                            p1_dir_wr,
  input  wire logic                            p1_lat_wr,
  input  wire logic                            p1_pu_wr,
  input  wire logic                            p4_dir_wr,
  input  wire logic                            p4_lat_wr,
  input  wire logic                            p4_pu_wr,
  input  wire logic [port_ctrl_pkg::PORT_W-1:0] analog_sel,
  input  wire logic [port_ctrl_pkg::PORT_W-1:0] port1_pins_i,
  output logic      [port_ctrl_pkg::PORT_W-1:0] port1_pins_o,
  output logic      [port_ctrl_pkg::PORT_W-1:0] port1_pins_oe,
  output logic      [port_ctrl_pkg::PORT_W-1:0] port1_pullup,
  output logic      [port_ctrl_pkg::PORT_W-1:0] port1_val,
  input  wire logic [port_ctrl_pkg::PORT_W-1:0] port4_pins_i,
  output logic      [port_ctrl_pkg::PORT_W-1:0] port4_pins_o,
  output logic      [port_ctrl_pkg::PORT_W-1:0] port4_pins_oe,
  output logic      [port_ctrl_pkg::PORT_W-1:0] port4_pullup,
  output logic      [port_ctrl_pkg::PORT_W-1:0] port4_val,
  input  wire logic                            flag_clr,
  output logic                                 falling_edge_test_flag,
  input  wire logic [port_ctrl_pkg::IRQ_N-1:0]  ext_irq_pins,
  input  wire logic [2*port_ctrl_pkg::IRQ_N-1:0] irq_edge_sel,
  output logic      [port_ctrl_pkg::IRQ_N-1:0]  irq_req,
  input  wire logic [7:0]                      processor_clock_control,
  input  wire logic                            subclock_shared_input_pin,
  output logic                                 subclock_input_valid,
  output logic                                 subclock_input_val
);
  import port_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Port bit cells.
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_bits
      port_bit_cell u_p1 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .wr_dir     (p1_dir_wr),
        .wr_lat     (p1_lat_wr),
        .wr_pu      (p1_pu_wr),
        .dir_in     (wr_data[gi]),
        .lat_in     (wr_data[gi]),
        .pu_in      (wr_data[gi]),
        .analog_sel (analog_sel[gi]),
        .pin_i      (port1_pins_i[gi]),
        .pin_o      (port1_pins_o[gi]),
        .pin_oe     (port1_pins_oe[gi]),
        .pullup_en  (port1_pullup[gi]),
        .pin_val    (port1_val[gi])
      );
      port_bit_cell u_p4 (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .wr_dir     (p4_dir_wr),
        .wr_lat     (p4_lat_wr),
        .wr_pu      (p4_pu_wr),
        .dir_in     (wr_data[gi]),
        .lat_in     (wr_data[gi]),
        .pu_in      (wr_data[gi]),
        .analog_sel (1'b0),
        .pin_i      (port4_pins_i[gi]),
        .pin_o      (port4_pins_o[gi]),
        .pin_oe     (port4_pins_oe[gi]),
        .pullup_en  (port4_pullup[gi]),
        .pin_val    (port4_val[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Falling edge test flag on port 4; a set wins over a clear.
  logic [PORT_W-1:0] p4_prev_q;
  logic              flag_q;
  logic              p4_fall;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      p4_prev_q <= '1;
    end else begin
      p4_prev_q <= port4_pins_i;
    end
  end

  assign p4_fall = |(p4_prev_q & ~port4_pins_i);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (p4_fall) begin
      flag_q <= 1'b1;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  assign falling_edge_test_flag = flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt edge detection.
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  logic [IRQ_N-1:0] irq_prev_q;
  logic [IRQ_N-1:0] irq_req_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_prev_q <= '0;
    end else begin
      irq_prev_q <= ext_irq_pins;
    end
  end

  generate
    for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          irq_req_q[gi] <= 1'b0;
        end else begin
          irq_req_q[gi] <= edge_hit(irq_edge_sel[2*gi +: 2], irq_prev_q[gi],
                                    ext_irq_pins[gi]);
        end
      end
    end
  endgenerate

  assign irq_req = irq_req_q;

  ////////////////////////////////////////////////////////////////////////////
  // Subclock shared input: valid only once the feedback resistor is cut.
  logic sub_val_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sub_val_q <= 1'b0;
    end else begin
      sub_val_q <= subclock_shared_input_pin;
    end
  end

  assign subclock_input_valid = processor_clock_control[FRC_BIT];
  assign subclock_input_val   = sub_val_q & processor_clock_control[FRC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_reset_inputs: assert property (@(posedge ref_clk)
    rst |=> (port1_pins_oe == '0 && port4_pins_oe == '0 &&
                    port1_pullup == '0 && port4_pullup == '0))
    else $error("pins not input after reset");
  a_dir_write: assert property (@(posedge ref_clk) disable iff (rst)
    p1_dir_wr |=> port1_pins_oe == ~$past(wr_data))
    else $error("direction write not applied");
  a_p4_dir_write: assert property (@(posedge ref_clk) disable iff (rst)
    p4_dir_wr |=> port4_pins_oe == ~$past(wr_data))
    else $error("port 4 direction write not applied");
  a_lat_write: assert property (@(posedge ref_clk) disable iff (rst)
    p1_lat_wr |=> port1_pins_o == $past(wr_data))
    else $error("latch write not applied");
  a_pu_out_off: assert property (@(posedge ref_clk) disable iff (rst)
    (port4_pullup & port4_pins_oe) == '0)
    else $error("pull-up on output pin");
  a_p1_pu_out: assert property (@(posedge ref_clk) disable iff (rst)
    (port1_pullup & port1_pins_oe) == '0)
    else $error("pull-up on port 1 output pin");
  a_pu_analog: assert property (@(posedge ref_clk) disable iff (rst)
    (port1_pullup & analog_sel) == '0)
    else $error("pull-up on analog pin");
  a_flag_fall: assert property (@(posedge ref_clk) disable iff (rst)
    (|($past(port4_pins_i) & ~port4_pins_i)) |=> falling_edge_test_flag)
    else $error("falling edge did not set flag");
  a_flag_hold: assert property (@(posedge ref_clk) disable iff (rst)
    falling_edge_test_flag && !flag_clr |=> falling_edge_test_flag)
    else $error("flag lost without clear");
  a_irq_rise: assert property (@(posedge ref_clk) disable iff (rst)
    (irq_edge_sel[1:0] == EDGE_RISING && $rose(ext_irq_pins[0])) |=> irq_req[0])
    else $error("rising edge missed");
  a_irq_fall_only: assert property (@(posedge ref_clk) disable iff (rst)
    (irq_edge_sel[1:0] == EDGE_FALLING && $rose(ext_irq_pins[0])) |=> !irq_req[0])
    else $error("rising edge taken in falling mode");
  a_irq_fall: assert property (@(posedge ref_clk) disable iff (rst)
    (!$past(rst) && irq_edge_sel[1:0] == EDGE_FALLING &&
     $fell(ext_irq_pins[0])) |=> irq_req[0])
    else $error("falling edge missed");
  a_irq_none: assert property (@(posedge ref_clk) disable iff (rst)
    irq_edge_sel[1:0] == EDGE_NONE |=> !irq_req[0])
    else $error("edge taken with detection off");
  a_sub_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !processor_clock_control[FRC_BIT] |-> !subclock_input_val)
    else $error("subclock input passed without cut");

  c_flag_set: cover property (@(posedge ref_clk) disable iff (rst) $rose(falling_edge_test_flag));
  c_irq_both: cover property (@(posedge ref_clk) disable iff (rst)
    irq_edge_sel[1:0] == EDGE_BOTH ##1 irq_req[0]);
  c_output: cover property (@(posedge ref_clk) disable iff (rst) |port1_pins_oe);

  // Scenario coverage for analog select and the subclock input.
  c_analog: cover property (@(posedge ref_clk) disable iff (rst)
    (|analog_sel) && (|port1_pullup));
  c_sub_input: cover property (@(posedge ref_clk) disable iff (rst) $rose(subclock_input_val));
endmodule

/* rtl/port_bit_cell.sv */
// Purpose: One bidirectional port bit with direction, latch and pull-up.
// Assumes: Inputs synchronous to ref_clk.
// Notes:   Pull-up is suppressed in output mode and when analog is selected.
`timescale 1ns/10ps
module port_bit_cell (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic wr_dir,
  input  wire logic wr_lat,
  input  wire logic wr_pu,
  input  wire logic dir_in,
  input  wire logic lat_in,
  input  wire logic pu_in,
  input  wire logic analog_sel,
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe,
  output logic      pullup_en,
  output logic      pin_val
);
  logic dir_q;
  logic lat_q;
  logic pu_q;
  logic val_q;

  // Direction bit: 1 means input.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_q <= 1'b1;
    end else if (wr_dir) begin
      dir_q <= dir_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lat_q <= 1'b0;
    end else if (wr_lat) begin
      lat_q <= lat_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pu_q <= 1'b0;
    end else if (wr_pu) begin
      pu_q <= pu_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      val_q <= 1'b0;
    end else begin
      val_q <= dir_q ? pin_i : lat_q;
    end
  end

  assign pin_o     = lat_q;
  assign pin_oe    = ~dir_q;
  assign pullup_en = pu_q & dir_q & ~analog_sel;
  assign pin_val   = val_q;
endmodule

/* rtl/port_ctrl_pkg.sv */
// Purpose: Shared constants for the port pin control block.
// Assumes: One core clock, synchronous active-high reset.
// Notes:   Widths follow the port pin counts.
package port_ctrl_pkg;
  localparam int unsigned PORT_W     = 8;
  localparam int unsigned IRQ_N      = 7;
  localparam int unsigned FRC_BIT    = 6;
  localparam logic [7:0]  DIR_RESET  = 8'hff;
  localparam logic [7:0]  PU_RESET   = 8'h00;
  localparam logic [7:0]  LAT_RESET  = 8'h00;
  typedef enum logic [1:0] {
    EDGE_NONE    = 2'b00,
    EDGE_RISING  = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_BOTH    = 2'b11
  } edge_sel_t;
endpackage

/* tb/board_model.sv */
// Purpose: Board circuitry on one eight-bit port: drivers, pull-ups, open lines.
// Assumes: The device wins where it drives; an open line without pull-up wanders.
// Notes:   A floating bit shows the inverse of its last level each cycle.
`timescale 1ns/10ps
module board_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] pins_o,
  input  wire logic [7:0] pins_oe,
  input  wire logic [7:0] pu_en,
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] drv_val,
  output logic      [7:0] pins_i
);
  logic [7:0] last_q;
  always_ff @(posedge ref_clk) begin
    last_q <= pins_i;
  end
  always_comb begin
    pins_i = (pins_oe & pins_o) | (~pins_oe & drv_en & drv_val)
           | (~pins_oe & ~drv_en & (pu_en | ~last_q));
  end
endmodule

/* tb/tb.sv */
// Purpose: Self-checking bench for the port pin control block.
// Assumes: Notes of expected values are queued by the driver, checked at negedge.
// Notes:   Random data comes from an xorshift seeded with 53.
`timescale 1ns/10ps
module tb;
  import port_ctrl_pkg::*;
  typedef struct {int due; int sel; logic [7:0] exp;} note_t;
  logic        ref_clk, rst, flag_clr, falling_edge_test_flag;
  logic        subclock_shared_input_pin, subclock_input_valid, subclock_input_val;
  logic [7:0]  wr_data, analog_sel, processor_clock_control, d1, d4, a, drv4, en4;
  logic [7:0]  port1_pins_i, port1_pins_o, port1_pins_oe, port1_pullup, port1_val;
  logic [7:0]  port4_pins_i, port4_pins_o, port4_pins_oe, port4_pullup, port4_val;
  logic [5:0]  strb;
  logic [6:0]  ext_irq_pins, irq_req;
  logic [13:0] irq_edge_sel;
  logic [31:0] rs;
  note_t       q[$];
  note_t       n;
  int          cyc, mismatches, cmp_count, irq_tot, exp_irq;
  mcu_port_pin_control DUT (.ref_clk, .rst, .wr_data, .p1_dir_wr(strb[0]),
    .p1_lat_wr(strb[1]), .p1_pu_wr(strb[2]), .p4_dir_wr(strb[3]), .p4_lat_wr(strb[4]),
    .p4_pu_wr(strb[5]), .analog_sel, .port1_pins_i, .port1_pins_o, .port1_pins_oe,
    .port1_pullup, .port1_val, .port4_pins_i, .port4_pins_o, .port4_pins_oe,
    .port4_pullup, .port4_val, .flag_clr, .falling_edge_test_flag, .ext_irq_pins,
    .irq_edge_sel, .irq_req, .processor_clock_control, .subclock_shared_input_pin,
    .subclock_input_valid, .subclock_input_val);
  board_model b1 (.ref_clk, .pins_o(port1_pins_o), .pins_oe(port1_pins_oe),
    .pu_en(port1_pullup), .drv_en(8'hff), .drv_val(8'h3c), .pins_i(port1_pins_i));
  board_model b4 (.ref_clk, .pins_o(port4_pins_o), .pins_oe(port4_pins_oe),
    .pu_en(port4_pullup), .drv_en(en4), .drv_val(drv4), .pins_i(port4_pins_i));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction
  function automatic logic [7:0] obs(input int s);
    case (s)
      0: return port1_pins_oe;
      1: return port4_pins_oe;
      2: return port1_pullup;
      3: return port4_pullup;
      4: return {7'h00, falling_edge_test_flag};
      5: return irq_tot[7:0];
      6: return {6'h00, subclock_input_valid, subclock_input_val};
      8: return port4_val;
      9: return port4_pins_o;
      default: return port1_val;
    endcase
  endfunction
  task automatic note(input int s, input logic [7:0] e, input int dly);
    q.push_back('{cyc + dly, s, e});
  endtask
  task automatic wr(input int idx, input logic [7:0] d);
    @(posedge ref_clk);
    wr_data <= d;
    strb <= 6'h01 << idx;
    @(posedge ref_clk);
    strb <= 6'h00;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (rst) irq_tot <= 0;
    else irq_tot <= irq_tot + $countones(irq_req);
  end
  always @(negedge ref_clk) begin
    cyc = cyc + 1;
    while (q.size() > 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      cmp_count++;
      if (obs(n.sel) !== n.exp) begin
        mismatches++;
        $display("mismatch at %0t: sel %0d got %h exp %h", $time, n.sel, obs(n.sel), n.exp);
      end
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #8000;
    mismatches++;
    final_report();
  end
  initial begin
    rs = 32'd53;
    cyc = 0;
    mismatches = 0;
    cmp_count = 0;
    exp_irq = 0;
    rst = 1'b1;
    strb = 6'h00;
    wr_data = 8'h00;
    analog_sel = 8'h00;
    processor_clock_control = 8'h00;
    subclock_shared_input_pin = 1'b0;
    flag_clr = 1'b0;
    ext_irq_pins = 7'h00;
    irq_edge_sel = 14'h0000;
    drv4 = 8'hff;
    en4 = 8'hff;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (int s = 0; s < 10; s++) note(s, 8'h00, 1);
    d1 = rnd();
    d4 = rnd();
    wr(0, d1);
    note(0, ~d1, 1);
    wr(3, d4);
    note(1, ~d4, 1);
    wr(1, 8'ha5);
    note(7, (d1 & 8'h3c) | (~d1 & 8'ha5), 2);
    wr(2, 8'hff);
    note(2, d1, 1);
    wr(5, 8'hff);
    note(3, d4, 1);
    @(posedge ref_clk);
    a = rnd();
    analog_sel <= a;
    note(2, d1 & ~a, 1);
    wr(3, 8'hff);
    @(posedge ref_clk);
    flag_clr <= 1'b1;
    @(posedge ref_clk);
    flag_clr <= 1'b0;
    note(4, 8'h00, 1);
    @(posedge ref_clk);
    drv4 <= 8'hf7;
    note(4, 8'h01, 3);
    note(8, 8'hf7, 3);
    repeat (3) @(posedge ref_clk);
    en4 <= 8'h00;
    note(8, 8'hff, 2);
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk);
      irq_edge_sel <= {7{m[1:0]}};
      @(posedge ref_clk);
      ext_irq_pins <= 7'h7f;
      repeat (3) @(posedge ref_clk);
      ext_irq_pins <= 7'h00;
      repeat (3) @(posedge ref_clk);
      exp_irq = exp_irq + 7 * (int'(m[0]) + int'(m[1]));
      note(5, exp_irq[7:0], 1);
    end
    @(posedge ref_clk);
    processor_clock_control <= 8'h40;
    subclock_shared_input_pin <= 1'b1;
    note(6, 8'h03, 2);
    repeat (5) @(posedge ref_clk);
    final_report();
  end
endmodule
